// ===== src/mmt_regs.svh
`ifndef MMT_REGS_SVH
`define MMT_REGS_SVH

// ---------------------------------------------------------------------------
// Register byte offsets on the APB side.
// ---------------------------------------------------------------------------
`define MMT_OFS_CTRL      12'h000
`define MMT_OFS_COUNT     12'h004
`define MMT_OFS_STATUS    12'h008
`define MMT_OFS_MASK      12'h00c

// ---------------------------------------------------------------------------
// Register indices, control and status field positions, and the last valid mode value.
// ---------------------------------------------------------------------------
`define MMT_IDX_CTRL      2'h0
`define MMT_IDX_COUNT     2'h1
`define MMT_IDX_STATUS    2'h2
`define MMT_IDX_MASK      2'h3
`define MMT_CTRL_START    0
`define MMT_CTRL_MODE_LO  1
`define MMT_CTRL_MODE_HI  3
`define MMT_CTRL_MEAS_SEL 4
`define MMT_CTRL_FREE_RUN 5
`define MMT_CTRL_COUNT_UP 6
`define MMT_CTRL_EDGE_FALL 7
`define MMT_STAT_REQ      0
`define MMT_MODE_LAST     3'h4

// ---------------------------------------------------------------------------
// Reset values and fixed counter values.
// ---------------------------------------------------------------------------
`define MMT_ALL_ONES      16'hffff
`define MMT_ALL_ZERO      16'h0000
`define MMT_COUNT_RESET   16'hffff
`define MMT_RELOAD_RESET  16'hffff

`endif

// ===== src/mmt_pkg.sv
package mmt_pkg;

    // Operating modes of the general timer.
    typedef enum logic [2:0] {
        mmt_timer,
        mmt_event,
        mmt_oneshot,
        mmt_pwm,
        mmt_measure
    } mmt_mode_e;

    // One-shot run state.
    typedef enum logic {
        mmt_idle,
        mmt_run
    } mmt_run_e;

    typedef logic [15:0] mmt_count_t;

endpackage

// ===== src/mmt_edge.sv
`timescale 1ns/1ns
// Detects the selected edge of the timer pin input.
module mmt_edge (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic pin_in,
    input  wire logic edge_fall,
    input  wire logic both_edges,
    output logic      edge_pulse
);
    import mmt_pkg::*;

    logic prev;
    logic next_prev;

    // Remembers the last level to compare against.
    always_comb begin
        next_prev = pin_in;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prev <= 1'b0;
        end else begin
            prev <= next_prev;
        end
    end

    // Both edges, or only the rising or only the falling one.
    assign edge_pulse = both_edges ? (pin_in ^ prev) :
                        edge_fall  ? (prev & ~pin_in) : (pin_in & ~prev);
endmodule

// ===== src/mmt_apb.sv
`timescale 1ns/1ns
`include "mmt_regs.svh"
// Decodes APB requests into register strobes.
module mmt_apb (
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    output logic             wr_stb,
    output logic             rd_setup,
    output logic [1:0]       reg_idx,
    output logic             pslverr
);
    import mmt_pkg::*;

    // True when the offset names one of the four registers.
    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == `MMT_OFS_CTRL) || (a == `MMT_OFS_COUNT) ||
                   (a == `MMT_OFS_STATUS) || (a == `MMT_OFS_MASK);
    endfunction

    logic hit;

    // Writes act in the access phase, reads are captured in setup.
    assign hit      = addr_hit(paddr);
    assign reg_idx  = paddr[3:2];
    assign wr_stb   = psel & penable & pwrite & hit;
    assign rd_setup = psel & ~penable & ~pwrite & hit;
    assign pslverr  = psel & penable & ~hit;
endmodule

// ===== src/mmt_timer.sv
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`include "mmt_regs.svh"
// Notes on behaviour
// RULE1: A count read while running returns the live counter value.
// RULE2: In timer mode a count read at the reload moment returns ffff.
// RULE3: In event mode a read at reload returns ffff after underflow and 0000 after overflow.
// RULE4: A count written while halted reads back unchanged before counting starts.
// RULE5: Software rewrites the counter after stopping a free-running event count.
// RULE6: Clearing start during a one-shot count halts it and reloads the counter.
// RULE7: Aborting a one-shot count drives the pin low.
// RULE8: Aborting a one-shot count sets the interrupt request bit.
// RULE9: Entering one-shot mode from reset, timer or event mode sets the request bit.
// RULE10: Entering PWM mode from reset, timer or event mode sets the request bit.
// RULE11: Software clears the request bit after such mode changes.
// RULE12: Clearing start in PWM stops counting and, with the pin high, drives it low and sets the request.
// RULE13: Clearing start in PWM with the pin low leaves the pin and the request bit alone.
// RULE14: Changing the measurement select bit while counting sets the request bit.
// RULE15: The first valid measurement edge loads an undefined value and raises no request.
// RULE16: In timer mode the counter decrements, reloads on underflow and requests each time.
module mmt_timer (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timer_io_pin_in,
    output logic             timer_io_pin_out,
    output logic             timer_io_pin_oe_n,
    output logic             irq
);
    import mmt_pkg::*;

    // ------------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------------
    mmt_count_t count, next_count;
    mmt_count_t reload, next_reload;
    mmt_mode_e  mode, next_mode, wr_mode;
    mmt_run_e   run, next_run;
    logic       start, next_start;
    logic       meas_sel, next_meas_sel;
    logic       free_run, next_free_run;
    logic       count_up, next_count_up;
    logic       edge_fall, next_edge_fall;
    logic       first_edge, next_first_edge;
    logic       pin_out, next_pin_out;
    logic       req_flag, next_req_flag;
    logic       mask, next_mask;
    logic [31:0] next_prdata;
    logic       set_req;
    logic       reload_hit;
    logic       ovf_hit;
    logic       mode_ok;
    logic       new_start;
    logic       wr_stb;
    logic       rd_setup;
    logic [1:0] reg_idx;
    logic       pin_edge;

    // ------------------------------------------------------------------------
    // Bus decode and pin edge detection.
    // ------------------------------------------------------------------------
    mmt_apb u_apb (
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .wr_stb   (wr_stb),
        .rd_setup (rd_setup),
        .reg_idx  (reg_idx),
        .pslverr  (pslverr)
    );

    mmt_edge u_edge (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .pin_in     (timer_io_pin_in),
        .edge_fall  (edge_fall),
        .both_edges (meas_sel && mode == mmt_measure),
        .edge_pulse (pin_edge)
    );

    // Outputs: the pin is driven only in the pulse-producing modes.
    assign pready            = 1'b1;
    assign timer_io_pin_out  = pin_out;
    assign timer_io_pin_oe_n = ~(mode == mmt_oneshot || mode == mmt_pwm);
    assign irq               = req_flag & mask;

    // ------------------------------------------------------------------------
    // Next-state logic for counting, register writes and the request bit.
    // ------------------------------------------------------------------------
    always_comb begin
        next_count      = count;
        next_reload     = reload;
        next_mode       = mode;
        next_run        = run;
        next_start      = start;
        next_meas_sel   = meas_sel;
        next_free_run   = free_run;
        next_count_up   = count_up;
        next_edge_fall  = edge_fall;
        next_first_edge = first_edge;
        next_pin_out    = pin_out;
        next_req_flag   = req_flag;
        next_mask       = mask;
        next_prdata     = prdata;
        set_req         = 1'b0;
        reload_hit      = 1'b0;
        ovf_hit         = 1'b0;
        mode_ok         = pwdata[`MMT_CTRL_MODE_HI:`MMT_CTRL_MODE_LO] <= `MMT_MODE_LAST;
        wr_mode         = mode_ok ? mmt_mode_e'(pwdata[`MMT_CTRL_MODE_HI:`MMT_CTRL_MODE_LO]) : mode;
        new_start       = pwdata[`MMT_CTRL_START];
        // Counting step for the current mode.
        if (start) begin
            unique case (mode)
                mmt_timer: begin
                    if (count == `MMT_ALL_ZERO) begin
                        next_count = reload;                          // [RULE16]
                        set_req    = 1'b1;
                        reload_hit = 1'b1;
                    end else begin
                        next_count = count - 16'h0001;                // [RULE16]
                    end
                end
                mmt_event: begin
                    if (pin_edge && count_up) begin
                        if (count == `MMT_ALL_ONES) begin
                            next_count = free_run ? `MMT_ALL_ZERO : reload;
                            ovf_hit    = ~free_run;                   // [RULE3]
                            set_req    = 1'b1;
                        end else begin
                            next_count = count + 16'h0001;
                        end
                    end else if (pin_edge) begin
                        if (count == `MMT_ALL_ZERO) begin
                            next_count = free_run ? `MMT_ALL_ONES : reload;
                            reload_hit = ~free_run;                   // [RULE3]
                            set_req    = 1'b1;
                        end else begin
                            next_count = count - 16'h0001;
                        end
                    end
                end
                mmt_oneshot: begin
                    if (run == mmt_run && count == `MMT_ALL_ZERO) begin
                        next_count   = reload;
                        next_pin_out = 1'b0;
                        next_run     = mmt_idle;
                        next_start   = 1'b0;
                        set_req      = 1'b1;
                    end else if (run == mmt_run) begin
                        next_count = count - 16'h0001;
                    end
                end
                mmt_pwm: begin
                    if (count == `MMT_ALL_ZERO) begin
                        next_pin_out = ~pin_out;
                        next_count   = pin_out ? (`MMT_ALL_ONES - reload) : reload;
                        set_req      = pin_out;
                    end else begin
                        next_count = count - 16'h0001;
                    end
                end
                mmt_measure: begin
                    next_count = count + 16'h0001;
                    if (pin_edge) begin
                        next_reload     = count;
                        next_count      = `MMT_ALL_ZERO;
                        next_first_edge = 1'b0;
                        set_req         = ~first_edge;                // [RULE15]
                    end
                end
                default: begin
                    next_count = count;
                end
            endcase
        end
        // Register writes take effect in the access phase.
        if (wr_stb) begin
            unique case (reg_idx)
                `MMT_IDX_CTRL: begin
                    if ((mode == mmt_timer || mode == mmt_event) && wr_mode == mmt_oneshot) begin
                        set_req = 1'b1;                               // [RULE9]
                    end
                    if ((mode == mmt_timer || mode == mmt_event) && wr_mode == mmt_pwm) begin
                        set_req = 1'b1;                               // [RULE10]
                    end
                    if (start && mode == mmt_measure && pwdata[`MMT_CTRL_MEAS_SEL] != meas_sel) begin
                        set_req = 1'b1;                               // [RULE14]
                    end
                    if (start && !new_start && mode == mmt_oneshot && run == mmt_run) begin
                        next_count   = reload;                        // [RULE6]
                        next_pin_out = 1'b0;                          // [RULE7]
                        next_run     = mmt_idle;
                        set_req      = 1'b1;                          // [RULE8]
                    end
                    if (start && !new_start && mode == mmt_pwm) begin
                        next_count   = count;                         // [RULE12]
                        next_pin_out = 1'b0;                          // [RULE13]
                        set_req      = pin_out;                       // [RULE12] [RULE13]
                    end
                    if (!start && new_start) begin
                        next_first_edge = 1'b1;
                        next_pin_out    = wr_mode == mmt_oneshot || wr_mode == mmt_pwm;
                        next_run        = wr_mode == mmt_oneshot ? mmt_run : mmt_idle;
                        if (wr_mode == mmt_measure) begin
                            next_count = `MMT_ALL_ZERO;
                        end else if (wr_mode == mmt_oneshot || wr_mode == mmt_pwm) begin
                            next_count = reload;
                        end
                    end
                    next_mode      = wr_mode;
                    next_start     = new_start;
                    next_meas_sel  = pwdata[`MMT_CTRL_MEAS_SEL];
                    next_free_run  = pwdata[`MMT_CTRL_FREE_RUN];
                    next_count_up  = pwdata[`MMT_CTRL_COUNT_UP];
                    next_edge_fall = pwdata[`MMT_CTRL_EDGE_FALL];
                end
                `MMT_IDX_COUNT: begin
                    next_reload = pwdata[15:0];
                    if (!start) begin
                        next_count = pwdata[15:0];                    // [RULE4]
                    end
                end
                `MMT_IDX_STATUS: begin
                    if (pwdata[`MMT_STAT_REQ]) begin
                        next_req_flag = 1'b0;
                    end
                end
                `MMT_IDX_MASK: begin
                    next_mask = pwdata[0];
                end
            endcase
        end
        // A new request wins over a clear in the same cycle.
        if (set_req) begin
            next_req_flag = 1'b1;
        end
        // Read data is captured in the setup cycle.
        if (rd_setup) begin
            unique case (reg_idx)
                `MMT_IDX_CTRL: begin
                    next_prdata = {24'h000000, edge_fall, count_up, free_run, meas_sel, mode, start};
                end
                `MMT_IDX_COUNT: begin
                    next_prdata = {16'h0000, reload_hit ? `MMT_ALL_ONES :           // [RULE2] [RULE3]
                                   ovf_hit ? `MMT_ALL_ZERO : count};                // [RULE1] [RULE3]
                end
                `MMT_IDX_STATUS: begin
                    next_prdata = {31'h00000000, req_flag};
                end
                `MMT_IDX_MASK: begin
                    next_prdata = {31'h00000000, mask};
                end
            endcase
        end
    end

    // Registers all state.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            count      <= `MMT_COUNT_RESET;
            reload     <= `MMT_RELOAD_RESET;
            mode       <= mmt_timer;
            run        <= mmt_idle;
            start      <= 1'b0;
            meas_sel   <= 1'b0;
            free_run   <= 1'b0;
            count_up   <= 1'b0;
            edge_fall  <= 1'b0;
            first_edge <= 1'b0;
            pin_out    <= 1'b0;
            req_flag   <= 1'b0;
            mask       <= 1'b0;
            prdata     <= 32'h00000000;
        end else begin
            count      <= next_count;
            reload     <= next_reload;
            mode       <= next_mode;
            run        <= next_run;
            start      <= next_start;
            meas_sel   <= next_meas_sel;
            free_run   <= next_free_run;
            count_up   <= next_count_up;
            edge_fall  <= next_edge_fall;
            first_edge <= next_first_edge;
            pin_out    <= next_pin_out;
            req_flag   <= next_req_flag;
            mask       <= next_mask;
            prdata     <= next_prdata;
        end
    end

    // ------------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic ctrl_wr;
    logic stop_wr;
    assign ctrl_wr = wr_stb && reg_idx == `MMT_IDX_CTRL;
    assign stop_wr = ctrl_wr && start && !pwdata[`MMT_CTRL_START];

    chk_timer_reload: assert property (start && mode == mmt_timer && count == 16'h0000 && !wr_stb  // [RULE16]
        |=> count == $past(reload) && req_flag) else $error("Timer did not reload on underflow.");
    chk_timer_step: assert property (start && mode == mmt_timer && count != 16'h0000 && !wr_stb ##1 !wr_stb  // [RULE16]
        |-> count == $past(count) - 16'h0001) else $error("Timer did not decrement.");
    chk_live_read: assert property (rd_setup && reg_idx == `MMT_IDX_COUNT && !reload_hit && !ovf_hit  // [RULE1]
        |=> prdata[15:0] == $past(count)) else $error("Count read is not live.");
    chk_reload_read: assert property (rd_setup && reg_idx == `MMT_IDX_COUNT && start && mode == mmt_timer  // [RULE2]
        && count == 16'h0000 |=> prdata[15:0] == 16'hffff) else $error("Reload read not all ones.");
    chk_ovf_read: assert property (rd_setup && reg_idx == `MMT_IDX_COUNT && ovf_hit  // [RULE3]
        |=> prdata[15:0] == 16'h0000) else $error("Overflow read not zero.");
    chk_halt_write: assert property (wr_stb && reg_idx == `MMT_IDX_COUNT && !start  // [RULE4]
        |=> count == $past(pwdata[15:0])) else $error("Halted write lost.");
    chk_abort_reload: assert property (stop_wr && mode == mmt_oneshot && run == mmt_run  // [RULE6]
        |=> count == $past(reload) && run == mmt_idle) else $error("Abort did not reload.");
    chk_abort_pin: assert property (stop_wr && mode == mmt_oneshot && run == mmt_run  // [RULE7]
        |=> !timer_io_pin_out ##1 !timer_io_pin_out || start) else $error("Abort left pin high.");
    chk_abort_req: assert property (stop_wr && mode == mmt_oneshot && run == mmt_run  // [RULE8]
        |=> req_flag) else $error("Abort raised no request.");
    chk_oneshot_req: assert property (ctrl_wr && (mode == mmt_timer || mode == mmt_event)  // [RULE9]
        && pwdata[3:1] == 3'h2 |=> req_flag && mode == mmt_oneshot) else $error("One-shot entry no request.");
    chk_pwm_entry: assert property (ctrl_wr && (mode == mmt_timer || mode == mmt_event)  // [RULE10]
        && pwdata[3:1] == 3'h3 |=> req_flag && mode == mmt_pwm) else $error("PWM entry no request.");
    chk_pwm_high_stop: assert property (stop_wr && mode == mmt_pwm && pin_out  // [RULE12]
        |=> !pin_out && req_flag && !start) else $error("PWM high stop wrong.");
    chk_pwm_low_stop: assert property (stop_wr && mode == mmt_pwm && !pin_out  // [RULE13]
        |=> !pin_out && req_flag == $past(req_flag)) else $error("PWM low stop wrong.");
    chk_meas_sel_req: assert property (ctrl_wr && start && mode == mmt_measure  // [RULE14]
        && pwdata[`MMT_CTRL_MEAS_SEL] != meas_sel |=> req_flag) else $error("Select change no request.");
    chk_first_edge: assert property (start && mode == mmt_measure && pin_edge && first_edge && !wr_stb  // [RULE15]
        |=> $stable(req_flag) && !first_edge) else $error("First edge raised request.");
    cov_timer_wrap: cover property (start && mode == mmt_timer && count == 16'h0000);
    cov_oneshot_abort: cover property (stop_wr && mode == mmt_oneshot && run == mmt_run);
    cov_pwm_stop: cover property (stop_wr && mode == mmt_pwm && pin_out);
    cov_meas_capture: cover property (start && mode == mmt_measure && pin_edge && !first_edge);
endmodule

// ===== testbench/mmt_pin_model.sv
`timescale 1ns/1ns
// Outside party on the timer pin: a pulse source that yields while the timer drives the pin.
module mmt_pin_model (
    input  wire logic mclk,
    input  wire logic pin_out,
    input  wire logic pin_oe_n,
    output logic      pin_in
);
    logic ext = 1'b0;
    // The wire follows the timer while it drives, else the outside source.
    assign pin_in = pin_oe_n ? ext : pin_out;
    // Sends whole pulses, each edge three cycles apart.
    task automatic pulses(input int n);
        repeat (n) begin
            ext <= 1'b1;
            repeat (3) @(posedge mclk);
            ext <= 1'b0;
            repeat (3) @(posedge mclk);
        end
    endtask
endmodule

// ===== testbench/multimode_timer_tb.sv
`timescale 1ns/1ns
`include "mmt_regs.svh"
module multimode_timer_tb;
    import mmt_pkg::*;
    logic        mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'd71;
    logic        pready, pslverr, pin_in, pin_out, pin_oe_n, irq, last_err;
    logic [31:0] exp_q[$];
    int          errors = 0, checks_done = 0, n;
    mmt_timer mmt_timer_i (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_io_pin_in(pin_in), .timer_io_pin_out(pin_out), .timer_io_pin_oe_n(pin_oe_n), .irq(irq));
    mmt_pin_model mmt_pin_model_i (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));
    initial begin
        forever #10 mclk = ~mclk;
    end
    // -----------------------------------------------------------------
    // Shared tasks.
    // -----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // One APB transfer; a read notes its expected word for the monitor.
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [31:0] e);
        int k;
        if (!w) exp_q.push_back(e);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge mclk); k++; end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin errors++; conclude(); end
        last_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        // One idle edge keeps the release and the next setup apart.
        @(posedge mclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(a, 1'b1, d, 32'h0); endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e); apb(a, 1'b0, 32'h0, e); endtask
    task automatic wait_for(ref logic s, input logic v);
        n = 0;
        while (s !== v && n < 100) begin @(posedge mclk); n++; end
        if (n >= 100) begin errors++; conclude(); end
    endtask
    // Takes the oldest note whenever read data is handed over.
    always @(posedge mclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) check(prdata, exp_q.pop_front());
    end
    // -----------------------------------------------------------------
    // Main sequence.
    // -----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rd(`MMT_OFS_CTRL, 32'h0); rd(`MMT_OFS_COUNT, 32'hffff); rd(`MMT_OFS_MASK, 32'h0);
        rd(12'h010, 32'h0); check(last_err, 1'b1);
        seed = xs(seed);
        wr(`MMT_OFS_COUNT, {16'h0, seed[15:0]}); rd(`MMT_OFS_COUNT, {16'h0, seed[15:0]});
        wr(`MMT_OFS_COUNT, 32'h3); wr(`MMT_OFS_MASK, 32'h1); wr(`MMT_OFS_CTRL, 32'h01);
        wait_for(irq, 1'b1); wr(`MMT_OFS_CTRL, 32'h00); rd(`MMT_OFS_STATUS, 32'h1);
        wr(`MMT_OFS_MASK, 32'h0); check(irq, 1'b0);
        wr(`MMT_OFS_STATUS, 32'h1); rd(`MMT_OFS_STATUS, 32'h0);
        wr(`MMT_OFS_CTRL, 32'h04); rd(`MMT_OFS_STATUS, 32'h1); wr(`MMT_OFS_STATUS, 32'h1);
        wr(`MMT_OFS_COUNT, 32'h100); wr(`MMT_OFS_CTRL, 32'h05); @(posedge mclk);
        check({pin_out, pin_oe_n}, 2'b10); wr(`MMT_OFS_CTRL, 32'h04); @(posedge mclk);
        check(pin_out, 1'b0);
        rd(`MMT_OFS_COUNT, 32'h100); rd(`MMT_OFS_STATUS, 32'h1); wr(`MMT_OFS_STATUS, 32'h1);
        wr(`MMT_OFS_CTRL, 32'h02); wr(`MMT_OFS_CTRL, 32'h06); rd(`MMT_OFS_STATUS, 32'h1);
        wr(`MMT_OFS_STATUS, 32'h1); wr(`MMT_OFS_COUNT, 32'h4); wr(`MMT_OFS_CTRL, 32'h07);
        wr(`MMT_OFS_CTRL, 32'h06); @(posedge mclk); check(pin_out, 1'b0);
        rd(`MMT_OFS_STATUS, 32'h1); wr(`MMT_OFS_STATUS, 32'h1);
        wr(`MMT_OFS_CTRL, 32'h07); wait_for(pin_out, 1'b0); wr(`MMT_OFS_STATUS, 32'h1);
        wr(`MMT_OFS_CTRL, 32'h06); @(posedge mclk); check(pin_out, 1'b0);
        rd(`MMT_OFS_STATUS, 32'h0);
        wr(`MMT_OFS_CTRL, 32'h08); wr(`MMT_OFS_STATUS, 32'h1); wr(`MMT_OFS_CTRL, 32'h09);
        mmt_pin_model_i.pulses(1); repeat (3) @(posedge mclk); rd(`MMT_OFS_STATUS, 32'h0);
        wr(`MMT_OFS_CTRL, 32'h19); rd(`MMT_OFS_STATUS, 32'h1); wr(`MMT_OFS_STATUS, 32'h1);
        seed = xs(seed);
        wr(`MMT_OFS_CTRL, 32'h02); wr(`MMT_OFS_COUNT, 32'h5); wr(`MMT_OFS_CTRL, 32'h23);
        mmt_pin_model_i.pulses(1 + seed[1:0]); repeat (4) @(posedge mclk);
        rd(`MMT_OFS_COUNT, 32'h4 - {30'h0, seed[1:0]});
        wr(`MMT_OFS_CTRL, 32'h22); wr(`MMT_OFS_COUNT, 32'h5); rd(`MMT_OFS_COUNT, 32'h5);
        conclude();
    end
endmodule
